// File: rtl/cbs_pkg.sv
// Purpose: Constants and types for the bus-cycle side-signal block
// Assumes: 10 MHz system clock, APB register access
// Notes:   Offsets are byte addresses of 32-bit words
package cbs_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_STATUS  = 8'h04;
    localparam logic [7:0] OFF_MCADDR  = 8'h08;
    localparam logic [7:0] OFF_MCCTRL  = 8'h0c;
    localparam logic [7:0] OFF_PAGE    = 8'h10;
    localparam logic [7:0] OFF_CMD     = 8'h14;
    // ==========================================================
    // CTRL fields
    localparam int CTRL_MCE   = 0;   // machine check enable bit
    localparam int CTRL_PFS_LO = 1;  // pin function select low
    localparam int CTRL_PFS_HI = 2;  // pin function select high
    localparam int CTRL_RUN   = 3;   // not decoded; CMD_LEAVE resumes from idle
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // STATUS fields
    localparam int ST_MCPEND  = 0;
    localparam int ST_IDLE    = 1;
    localparam int ST_BUILTIN_SELFTEST    = 2;
    localparam int ST_TRI     = 3;
    localparam int ST_OUTST0  = 4;
    // PAGE fields
    localparam int PAGE_PWT   = 3;   // writethrough hint
    localparam int PAGE_PCD   = 4;   // cache disable hint
    // CMD fields
    localparam int CMD_PROBE  = 0;   // enter probe state
    localparam int CMD_MCACK  = 1;   // clear machine check pending
    localparam int CMD_LEAVE  = 2;   // leave probe/idle
    // Timing
    localparam int PARITY_CHECK_FLAG_DELAY   = 2;
    localparam int NA_DELAY     = 2;
    localparam int MAX_OUTSTAND = 2;
    // ==========================================================
    // Run state
    typedef enum logic [1:0] {
        RUN_EXEC  = 2'b00,
        RUN_IDLE  = 2'b01,
        RUN_PROBE = 2'b10
    } cbs_run_t;
endpackage

// File: rtl/cbs_side_signals.sv
// Purpose: Bus-cycle side signals: pipelining, parity, page hints,
//          debug pin mux, run/stop, reset straps
// Assumes: SYS_CLK 10 MHz; async inputs synchronised here
`timescale 1ns/1ps
module cbs_side_signals #(
    parameter int DATA_BYTES = 8
) (
    input  wire logic                    SYS_CLK,           // System clock
    input  wire logic                    RESET_N,           // Async reset, low
    // APB
    input  wire logic                    PSEL,              // Slave select
    input  wire logic                    PENABLE,           // Access phase
    input  wire logic                    PWRITE,            // Write direction
    input  wire logic [7:0]              PADDR,             // Byte address
    input  wire logic [31:0]             PWDATA,            // Write data
    output logic      [31:0]             PRDATA,            // Read data
    output logic                         PREADY,            // Always ready
    output logic                         PSLVERR,           // Unmapped access
    // Core request side
    input  wire logic                    CYCLE_REQ,         // Core wants a cycle
    input  wire logic [31:0]             CYCLE_ADDR,        // Address of request
    input  wire logic [3:0]              CYCLE_CTRL,        // Cycle definition
    input  wire logic                    CYCLE_LOCKED,      // Locked request
    input  wire logic                    CYCLE_MISALIGN,    // Misaligned request
    output logic                         CYCLE_ACK,         // Request taken
    input  wire logic                    INSTR_BOUNDARY,    // Core at boundary
    input  wire logic                    BP_MATCH0,         // Breakpoint 0 hit
    input  wire logic                    BP_MATCH1,         // Breakpoint 1 hit
    input  wire logic                    PM_EVENT0,         // Perf event 0
    input  wire logic                    PM_EVENT1,         // Perf event 1
    // Bus pins
    input  wire logic                    NEXT_ADDRESS_REQUEST_N, // Next address
    input  wire logic                    BURST_READY_IN_N,  // Data ready
    input  wire logic                    PARITY_ENABLE_IN_N, // Parity enable
    input  wire logic                    CYCLE_DONE,        // Last ready of cycle
    input  wire logic [DATA_BYTES*8-1:0] DATA_IN,           // Read data
    input  wire logic [DATA_BYTES-1:0]   DATA_PAR_IN,       // Even byte parity
    input  wire logic [DATA_BYTES-1:0]   BYTE_VALID,        // Valid lanes
    input  wire logic                    RUN_STOP_N,        // Run/stop pin
    input  wire logic                    CACHE_FLUSH_N,     // Strap at reset
    input  wire logic                    WARM_RESTART,      // Strap at reset
    output logic                         ADDRESS_STROBE_OUT_N, // Address strobe
    output logic                         PARITY_CHECK_FLAG_N,  // Parity flag
    output logic                         PAGE_CACHE_DISABLE_OUT, // Page hint
    output logic                         PAGE_WRITETHROUGH_OUT, // Page hint
    output logic [1:0]                   PERFMON_BREAKPOINT_PINS, // Muxed pins
    output logic                         PROBE_READY_OUT,   // Stopped
    output logic                         SPLIT_CYCLE_OUT,   // Split locked
    output logic                         MACHINE_CHECK,     // Exception request
    output logic                         CACHE_INVALIDATE,  // Invalidate pulse
    output logic                         BUILTIN_SELFTEST   // Self test run
);
    // Elaboration check on the lane count
    if (DATA_BYTES < 1 || DATA_BYTES > 8) begin
        $error("DATA_BYTES must be 1..8");
    end

    // ==========================================================
    // Synchronisers
    logic [1:0] na_s, rdy_s, pen_s, rs_s;
    logic       rs_prev_q;
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            na_s  <= 2'b11;
            rdy_s <= 2'b11;
            pen_s <= 2'b11;
            rs_s  <= 2'b11;
        end else begin
            na_s  <= {na_s[0], NEXT_ADDRESS_REQUEST_N};
            rdy_s <= {rdy_s[0], BURST_READY_IN_N};
            pen_s <= {pen_s[0], PARITY_ENABLE_IN_N};
            rs_s  <= {rs_s[0], RUN_STOP_N};
        end
    end
    wire na_act  = !na_s[1];
    wire rdy_act = !rdy_s[1];
    wire pen_act = !pen_s[1];

    // ==========================================================
    // Registers
    logic [31:0] ctrl_q, mc_addr_q, page_q;
    logic [3:0]  mc_ctrl_q;
    logic        mc_pend_q, builtin_selftest_q, tri_q, strap_done_q;
    cbs_pkg::cbs_run_t run_q;
    logic [1:0]  outst_q;
    wire wr_en = PSEL && PENABLE && PWRITE;
    wire cmd_wr = wr_en && PADDR == cbs_pkg::OFF_CMD;

    // Control and page register writes
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_q <= cbs_pkg::CTRL_RESET;
            page_q <= 32'h0000_0000;
        end else if (wr_en && PADDR == cbs_pkg::OFF_CTRL) begin
            ctrl_q <= PWDATA;
        end else if (wr_en && PADDR == cbs_pkg::OFF_PAGE) begin
            page_q <= PWDATA;
        end
    end

    // APB read mux and response
    always_comb begin
        PREADY  = 1'b1;
        PSLVERR = 1'b0;
        PRDATA  = 32'h0000_0000;
        unique case (PADDR)
            cbs_pkg::OFF_CTRL:   PRDATA = ctrl_q;
            cbs_pkg::OFF_STATUS: PRDATA = {26'h0, outst_q, tri_q, builtin_selftest_q,
                                           run_q != cbs_pkg::RUN_EXEC, mc_pend_q};
            cbs_pkg::OFF_MCADDR: PRDATA = mc_addr_q;
            cbs_pkg::OFF_MCCTRL: PRDATA = {28'h0, mc_ctrl_q};
            cbs_pkg::OFF_PAGE:   PRDATA = page_q;
            cbs_pkg::OFF_CMD:    PRDATA = 32'h0000_0000;
            default:             PSLVERR = PSEL && PENABLE;
        endcase
    end

    // ==========================================================
    // Reset straps, caught on first clock after release
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            strap_done_q <= 1'b0;
            builtin_selftest_q       <= 1'b0;
            tri_q        <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            builtin_selftest_q       <= WARM_RESTART;
            tri_q        <= !CACHE_FLUSH_N;
        end
    end
    assign BUILTIN_SELFTEST = builtin_selftest_q;
    assign CACHE_INVALIDATE = !strap_done_q;              // no writeback path

    // ==========================================================
    // Next-address pipelining
    logic       na_dly_q;
    logic       ads_q, pend_q;
    wire take = CYCLE_REQ && outst_q < 2'(cbs_pkg::MAX_OUTSTAND)
                && !pend_q && run_q == cbs_pkg::RUN_EXEC;
    assign CYCLE_ACK = take;
    wire first_issue = take && outst_q == 2'd0;
    wire done = CYCLE_DONE && rdy_act;
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            na_dly_q <= 1'b0;
            pend_q   <= 1'b0;
            ads_q    <= 1'b0;
            outst_q  <= 2'd0;
        end else begin
            // One strobe per pending cycle, even if the request is held
            na_dly_q <= na_act && pend_q && !na_dly_q;
            ads_q    <= first_issue || na_dly_q;
            if (take && !first_issue)
                pend_q <= 1'b1;
            else if (na_dly_q)
                pend_q <= 1'b0;
            // At most two in flight
            outst_q <= outst_q + 2'(take) - 2'(done && outst_q != 2'd0);
        end
    end
    assign ADDRESS_STROBE_OUT_N = !ads_q;

    // ==========================================================
    // Parity check, two-clock delay
    function automatic logic par_err(input logic [DATA_BYTES*8-1:0] d,
                                     input logic [DATA_BYTES-1:0] p,
                                     input logic [DATA_BYTES-1:0] v);
        logic e;
        e = 1'b0;
        for (int i = 0; i < DATA_BYTES; i++)
            if (v[i] && ((^d[i*8 +: 8]) ^ p[i]))
                e = 1'b1;
        return e;
    endfunction
    logic [cbs_pkg::PARITY_CHECK_FLAG_DELAY-1:0] perr_q;
    logic [31:0] addr_q;
    logic [3:0]  ctl_q;
    wire perr_now = rdy_act && par_err(DATA_IN, DATA_PAR_IN, BYTE_VALID);
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            perr_q <= '0;
            addr_q <= 32'h0000_0000;
            ctl_q  <= 4'h0;
        end else begin
            perr_q <= {perr_q[cbs_pkg::PARITY_CHECK_FLAG_DELAY-2:0], perr_now};
            if (take) begin
                addr_q <= CYCLE_ADDR;
                ctl_q  <= CYCLE_CTRL;
            end
        end
    end
    assign PARITY_CHECK_FLAG_N = !perr_q[cbs_pkg::PARITY_CHECK_FLAG_DELAY-1];

    // Machine check latch; set wins over clear
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mc_addr_q <= 32'h0000_0000;
            mc_ctrl_q <= 4'h0;
            mc_pend_q <= 1'b0;
        end else if (perr_now && pen_act) begin
            mc_addr_q <= addr_q;
            mc_ctrl_q <= ctl_q;
            mc_pend_q <= 1'b1;
        end else if (cmd_wr && PWDATA[cbs_pkg::CMD_MCACK]) begin
            mc_pend_q <= 1'b0;
        end
    end
    assign MACHINE_CHECK = mc_pend_q && ctrl_q[cbs_pkg::CTRL_MCE]
                           && INSTR_BOUNDARY;

    // ==========================================================
    // Page hints and split flag
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PAGE_CACHE_DISABLE_OUT <= 1'b0;
            PAGE_WRITETHROUGH_OUT  <= 1'b0;
            SPLIT_CYCLE_OUT        <= 1'b0;
        end else if (take) begin
            PAGE_CACHE_DISABLE_OUT <= page_q[cbs_pkg::PAGE_PCD];
            PAGE_WRITETHROUGH_OUT  <= page_q[cbs_pkg::PAGE_PWT];
            SPLIT_CYCLE_OUT <= CYCLE_LOCKED && CYCLE_MISALIGN;
        end
    end

    // Debug pin mux
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N)
            PERFMON_BREAKPOINT_PINS <= 2'b00;
        else begin
            PERFMON_BREAKPOINT_PINS[0] <= ctrl_q[cbs_pkg::CTRL_PFS_LO]
                                          ? BP_MATCH0 : PM_EVENT0;
            PERFMON_BREAKPOINT_PINS[1] <= ctrl_q[cbs_pkg::CTRL_PFS_HI]
                                          ? BP_MATCH1 : PM_EVENT1;
        end
    end

    // ==========================================================
    // Run/stop and probe state
    logic stop_req_q;
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rs_prev_q  <= 1'b1;
            stop_req_q <= 1'b0;
            run_q      <= cbs_pkg::RUN_EXEC;
        end else begin
            rs_prev_q <= rs_s[1];
            unique case (run_q)
                cbs_pkg::RUN_EXEC: begin
                    if (cmd_wr && PWDATA[cbs_pkg::CMD_PROBE])
                        run_q <= cbs_pkg::RUN_PROBE;
                    else if (stop_req_q && INSTR_BOUNDARY) begin
                        run_q      <= cbs_pkg::RUN_IDLE;
                        stop_req_q <= 1'b0;
                    end
                end
                default: begin
                    if (cmd_wr && PWDATA[cbs_pkg::CMD_LEAVE])
                        run_q <= cbs_pkg::RUN_EXEC;
                end
            endcase
            // A new falling edge wins over the clear on idle entry
            if (rs_prev_q && !rs_s[1])
                stop_req_q <= 1'b1;
        end
    end
    assign PROBE_READY_OUT = run_q != cbs_pkg::RUN_EXEC;

    // ==========================================================
    // Assertions
    // Pipelining, parity, machine check, pin mux and page hints
    ads_after_na_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (na_act && pend_q && !na_dly_q) |-> ##2 !ADDRESS_STROBE_OUT_N)
        else $error("strobe not two clocks after next address");
    outstanding_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        outst_q <= 2'd2)
        else $error("more than two cycles outstanding");
    parity_check_flag_delay_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        perr_now |-> ##2 !PARITY_CHECK_FLAG_N)
        else $error("parity flag not two clocks after ready");
    parity_check_flag_quiet_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        !$past(perr_now, 2) |-> PARITY_CHECK_FLAG_N)
        else $error("parity flag low without error");
    lane_mask_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (BYTE_VALID == '0) |-> !perr_now)
        else $error("error on invalid lanes");
    mc_latch_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (perr_now && pen_act) |=> (mc_pend_q && mc_addr_q == $past(addr_q)))
        else $error("machine check not latched");
    mc_enable_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        MACHINE_CHECK |-> ctrl_q[cbs_pkg::CTRL_MCE])
        else $error("machine check without enable");
    pin_mux_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        !ctrl_q[cbs_pkg::CTRL_PFS_LO] |=> PERFMON_BREAKPOINT_PINS[0] == $past(PM_EVENT0))
        else $error("pin 0 not in monitor mode");
    pin_mux_hi_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        ctrl_q[cbs_pkg::CTRL_PFS_HI] |=> PERFMON_BREAKPOINT_PINS[1] == $past(BP_MATCH1))
        else $error("pin 1 not in breakpoint mode");
    page_hint_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        take |=> (PAGE_CACHE_DISABLE_OUT == $past(page_q[cbs_pkg::PAGE_PCD])
                  && PAGE_WRITETHROUGH_OUT == $past(page_q[cbs_pkg::PAGE_PWT])))
        else $error("page hints not taken with request");
    // Run/stop, probe and split flag
    run_stop_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (rs_prev_q && !rs_s[1]) |=> stop_req_q)
        else $error("run/stop edge not latched");
    probe_rdy_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (stop_req_q && INSTR_BOUNDARY && run_q == cbs_pkg::RUN_EXEC
         && !cmd_wr) |=> PROBE_READY_OUT)
        else $error("probe ready not raised after stop");
    split_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (take && CYCLE_LOCKED && CYCLE_MISALIGN) |=> SPLIT_CYCLE_OUT)
        else $error("split flag missing");

    // Main scenarios reached
    pipelined_c: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
        outst_q == 2'd2);
    split_c: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
        SPLIT_CYCLE_OUT);
    parity_c: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
        !PARITY_CHECK_FLAG_N);
    mc_c: cover property (@(posedge SYS_CLK) disable iff (!RESET_N) MACHINE_CHECK);
    idle_c: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
        run_q == cbs_pkg::RUN_IDLE);
endmodule

// File: sim/cbs_bus_partner.sv
// Purpose: Memory-system model on the far side of the bus pins
// Assumes: Bench calls its tasks, one transfer at a time
// Notes:   Released data lines show the inverse of their last value
`timescale 1ns/1ps
module cbs_bus_partner (
    input  wire logic        sys_clk, // Bus clock
    output logic             na_n,    // Next address request
    output logic             rdy_n,   // Burst ready
    output logic             pen_n,   // Parity enable
    output logic             done,    // Last ready, aligned to synced ready
    output logic [63:0]      data,    // Read data
    output logic [7:0]       par,     // Byte parity
    output logic [7:0]       valid    // Valid lanes
);
    // ==========================================================
    // Idle levels; the split flag is never looked at here
    initial begin
        na_n = 1'h1;
        rdy_n = 1'h1;
        pen_n = 1'h1;
        done = 1'h0;
        data = 64'h5a5a_5a5a_5a5a_5a5a;
        par = 8'h3c;
        valid = 8'h0f;
    end
    // Early request for the next cycle, data still owed
    task automatic next_addr();
        @(posedge sys_clk);
        na_n <= 1'h0;
        @(posedge sys_clk);
        na_n <= 1'h1;
    endtask
    // One data transfer, after an optional stall
    task automatic give_data(input logic [63:0] d, input logic [7:0] p,
                             input logic [7:0] v, input logic pn, input int stall);
        repeat (stall) @(posedge sys_clk);
        @(posedge sys_clk);
        rdy_n <= 1'h0;
        data <= d;
        par <= p;
        valid <= v;
        pen_n <= pn;
        @(posedge sys_clk);
        rdy_n <= 1'h1;
        @(posedge sys_clk);
        done <= 1'h1;
        @(posedge sys_clk);
        done <= 1'h0;
        data <= ~d;
        par <= ~p;
        valid <= ~v;
        pen_n <= 1'h1;
    endtask
endmodule

// File: sim/cbs_side_signals_tb.sv
// Purpose: Self-checking bench for the bus-cycle side-signal block
// Assumes: Zero-wait APB slave, partner model on the bus pins
// Notes:   Parity rows in a table, pipeline and debug cases by hand
`timescale 1ns/1ps
module cbs_side_signals_tb;
    typedef struct packed {logic [7:0] flip; logic [7:0] valid; logic pen_n; logic mce;} cbs_row_t;
    localparam logic [63:0] D = 64'h0123_4567_89ab_cdef;
    logic SYS_CLK = 1'h0, RESET_N = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
    logic [7:0] PADDR = 8'h0;
    logic [31:0] PWDATA = 32'h0, CYCLE_ADDR = 32'h0, PRDATA, rdv;
    logic [3:0] CYCLE_CTRL = 4'h0;
    logic CYCLE_REQ = 1'h0, CYCLE_LOCKED = 1'h0, CYCLE_MISALIGN = 1'h0, INSTR_BOUNDARY = 1'h1;
    logic BP_MATCH0 = 1'h1, BP_MATCH1 = 1'h0, PM_EVENT0 = 1'h0, PM_EVENT1 = 1'h1;
    logic RUN_STOP_N = 1'h1, CACHE_FLUSH_N = 1'h1, WARM_RESTART = 1'h0, erv, got;
    logic NEXT_ADDRESS_REQUEST_N, BURST_READY_IN_N, PARITY_ENABLE_IN_N, CYCLE_DONE;
    logic [63:0] DATA_IN;
    logic [7:0] DATA_PAR_IN, BYTE_VALID;
    logic PREADY, PSLVERR, CYCLE_ACK, ADDRESS_STROBE_OUT_N, PARITY_CHECK_FLAG_N;
    logic PAGE_CACHE_DISABLE_OUT, PAGE_WRITETHROUGH_OUT, PROBE_READY_OUT, SPLIT_CYCLE_OUT;
    logic MACHINE_CHECK, CACHE_INVALIDATE, BUILTIN_SELFTEST, e, mc;
    logic [1:0] PERFMON_BREAKPOINT_PINS;
    int failures = 0, compares = 0, cyc = 0, lows = 0, strobes = 0, last_strobe = 0, l0, s0, nc;
    // Last row: bad parity on a lane that carries no valid data
    cbs_row_t rows [6] = '{'{8'h00, 8'hff, 0, 1}, '{8'h01, 8'hff, 1, 1},
                           '{8'h08, 8'hff, 0, 0}, '{8'h80, 8'hff, 0, 1}, '{8'h04, 8'hfb, 0, 1},
                           '{8'h10, 8'h00, 0, 1}};
    cbs_side_signals #(.DATA_BYTES(8)) dut (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .CYCLE_REQ(CYCLE_REQ),
        .CYCLE_ADDR(CYCLE_ADDR), .CYCLE_CTRL(CYCLE_CTRL), .CYCLE_LOCKED(CYCLE_LOCKED),
        .CYCLE_MISALIGN(CYCLE_MISALIGN), .CYCLE_ACK(CYCLE_ACK),
        .INSTR_BOUNDARY(INSTR_BOUNDARY), .BP_MATCH0(BP_MATCH0), .BP_MATCH1(BP_MATCH1),
        .PM_EVENT0(PM_EVENT0), .PM_EVENT1(PM_EVENT1),
        .NEXT_ADDRESS_REQUEST_N(NEXT_ADDRESS_REQUEST_N), .BURST_READY_IN_N(BURST_READY_IN_N),
        .PARITY_ENABLE_IN_N(PARITY_ENABLE_IN_N), .CYCLE_DONE(CYCLE_DONE), .DATA_IN(DATA_IN),
        .DATA_PAR_IN(DATA_PAR_IN), .BYTE_VALID(BYTE_VALID), .RUN_STOP_N(RUN_STOP_N),
        .CACHE_FLUSH_N(CACHE_FLUSH_N), .WARM_RESTART(WARM_RESTART),
        .ADDRESS_STROBE_OUT_N(ADDRESS_STROBE_OUT_N), .PARITY_CHECK_FLAG_N(PARITY_CHECK_FLAG_N),
        .PAGE_CACHE_DISABLE_OUT(PAGE_CACHE_DISABLE_OUT),
        .PAGE_WRITETHROUGH_OUT(PAGE_WRITETHROUGH_OUT),
        .PERFMON_BREAKPOINT_PINS(PERFMON_BREAKPOINT_PINS), .PROBE_READY_OUT(PROBE_READY_OUT),
        .SPLIT_CYCLE_OUT(SPLIT_CYCLE_OUT), .MACHINE_CHECK(MACHINE_CHECK),
        .CACHE_INVALIDATE(CACHE_INVALIDATE), .BUILTIN_SELFTEST(BUILTIN_SELFTEST));
    cbs_bus_partner bus (.sys_clk(SYS_CLK), .na_n(NEXT_ADDRESS_REQUEST_N),
        .rdy_n(BURST_READY_IN_N), .pen_n(PARITY_ENABLE_IN_N), .done(CYCLE_DONE),
        .data(DATA_IN), .par(DATA_PAR_IN), .valid(BYTE_VALID));
    // ==========================================================
    // Clock, edge counter and pulse monitors
    always #50 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) begin
        cyc <= cyc + 1;
        if (PARITY_CHECK_FLAG_N === 1'h0) lows <= lows + 1;
        if (ADDRESS_STROBE_OUT_N === 1'h0) begin
            strobes <= strobes + 1;
            last_strobe <= cyc;
        end
    end
    // Compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
        compares++;
        if (g !== x) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, x);
        end
    endtask
    // Verdict and end of run
    task automatic complete_run();
        if (failures == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // One APB transfer, held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'h1;
        do begin
            @(posedge SYS_CLK);
        end while (PREADY !== 1'h1);
        chk(PREADY, 1, "apb ready");
        rdv = PRDATA;
        erv = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
    endtask
    // Core request, held until taken or the limit runs out
    task automatic req(input logic [31:0] a, input logic lk, input logic ms, input int lim);
        @(posedge SYS_CLK);
        CYCLE_REQ <= 1'h1;
        CYCLE_ADDR <= a;
        CYCLE_CTRL <= a[7:4];
        CYCLE_LOCKED <= lk;
        CYCLE_MISALIGN <= ms;
        got = 1'h0;
        for (int n = 0; n < lim && got !== 1'h1; n++) begin
            @(posedge SYS_CLK);
            got = CYCLE_ACK;
        end
        CYCLE_REQ <= 1'h0;
    endtask
    function automatic logic [7:0] epar(input logic [63:0] d);
        for (int i = 0; i < 8; i++) epar[i] = ^d[i*8 +: 8];
    endfunction
    // Finish the oldest cycle with clean data
    task automatic fin();
        bus.give_data(D, epar(D), 8'hff, 1'h1, 1);
    endtask
    // Reset with the given straps, then check the known state
    task automatic do_reset(input logic warm, input logic fl_n);
        @(posedge SYS_CLK);
        RESET_N <= 1'h0;
        WARM_RESTART <= warm;
        CACHE_FLUSH_N <= fl_n;
        repeat (20) @(posedge SYS_CLK);
        chk(CACHE_INVALIDATE, 1, "invalidate in reset");
        chk(PROBE_READY_OUT, 0, "probe ready in reset");
        RESET_N <= 1'h1;
        repeat (3) @(posedge SYS_CLK);
        chk(CACHE_INVALIDATE, 0, "invalidate after");
        chk(BUILTIN_SELFTEST, warm, "self test");
        apb(0, cbs_pkg::OFF_STATUS, 0);
        chk(rdv[3:2], {~fl_n, warm}, "strap status");
        apb(0, cbs_pkg::OFF_CTRL, 0);
        chk(rdv, cbs_pkg::CTRL_RESET, "ctrl reset");
        if (fl_n) chk(PERFMON_BREAKPOINT_PINS, {PM_EVENT1, PM_EVENT0}, "pins reset");
    endtask
    // Watchdog
    initial begin
        #(6000 * 100);
        failures++;
        $display("[FAIL] %0t watchdog", $time);
        complete_run();
    end
    // Main sequence
    initial begin
        do_reset(0, 1);
        foreach (rows[i]) begin
            apb(1, cbs_pkg::OFF_CTRL, 32'(rows[i].mce) << cbs_pkg::CTRL_MCE);
            apb(1, cbs_pkg::OFF_CMD, 32'h1 << cbs_pkg::CMD_MCACK);
            req(32'h1000_0000 + 32'(i) * 16, 0, 0, 20);
            l0 = lows;
            bus.give_data(D, epar(D) ^ rows[i].flip, rows[i].valid, rows[i].pen_n, i);
            repeat (8) @(posedge SYS_CLK);
            e = |(rows[i].flip & rows[i].valid);
            mc = e & ~rows[i].pen_n;
            chk(lows - l0, e, "flag lows");
            apb(0, cbs_pkg::OFF_STATUS, 0);
            chk(rdv[0], mc, "mc pending");
            apb(0, cbs_pkg::OFF_MCADDR, 0);
            if (mc) chk(rdv, 32'h1000_0000 + 32'(i) * 16, "mc address");
            apb(0, cbs_pkg::OFF_MCCTRL, 0);
            if (mc) chk(rdv, 32'(i), "mc control");
            chk(MACHINE_CHECK, mc & rows[i].mce, "machine check");
        end
        for (int k = 0; k < 4; k++) begin
            apb(1, cbs_pkg::OFF_CTRL, 32'(k) << cbs_pkg::CTRL_PFS_LO);
            repeat (2) @(posedge SYS_CLK);
            chk(PERFMON_BREAKPOINT_PINS, {k[1] ? BP_MATCH1 : PM_EVENT1,
                k[0] ? BP_MATCH0 : PM_EVENT0}, "pin mux");
            apb(1, cbs_pkg::OFF_PAGE, (32'(k[1]) << 4) | (32'(k[0]) << 3));
            req(32'h3000_0000, 1, k[0], 20);
            @(posedge SYS_CLK);
            chk(PAGE_CACHE_DISABLE_OUT, k[1], "cache disable");
            chk(PAGE_WRITETHROUGH_OUT, k[0], "writethrough");
            chk(SPLIT_CYCLE_OUT, k[0], "split");
            fin();
        end
        s0 = strobes;
        req(32'h2000_0000, 0, 0, 20);
        req(32'h2000_0010, 0, 0, 20);
        chk(got, 1, "second take");
        repeat (6) @(posedge SYS_CLK);
        chk(strobes - s0, 1, "pending waits");
        bus.next_addr();
        nc = cyc;
        repeat (8) @(posedge SYS_CLK);
        chk(strobes - s0, 2, "pipelined strobe");
        chk((last_strobe - nc) inside {[3:4]}, 1, "strobe delay");
        req(32'h2000_0020, 0, 0, 6);
        chk(got, 0, "third refused");
        apb(0, cbs_pkg::OFF_STATUS, 0);
        chk(rdv[5:4], 2, "outstanding");
        fin();
        fin();
        @(posedge SYS_CLK);
        INSTR_BOUNDARY <= 1'h0;
        RUN_STOP_N <= 1'h0;
        repeat (6) @(posedge SYS_CLK);
        chk(PROBE_READY_OUT, 0, "waits for boundary");
        INSTR_BOUNDARY <= 1'h1;
        repeat (6) @(posedge SYS_CLK);
        chk(PROBE_READY_OUT, 1, "stopped");
        RUN_STOP_N <= 1'h1;
        req(32'h4000_0000, 0, 0, 5);
        chk(got, 0, "stopped refuses");
        apb(1, cbs_pkg::OFF_CMD, 32'h1 << cbs_pkg::CMD_LEAVE);
        repeat (3) @(posedge SYS_CLK);
        chk(PROBE_READY_OUT, 0, "resumed");
        apb(1, cbs_pkg::OFF_CMD, 32'h1 << cbs_pkg::CMD_PROBE);
        repeat (3) @(posedge SYS_CLK);
        chk(PROBE_READY_OUT, 1, "probe state");
        apb(0, 8'h20, 0);
        chk(erv, 1, "unmapped");
        do_reset(1, 0);
        complete_run();
    end
endmodule
